// ---- shared/stc_cfg.svh ----
// Constants of the stepper translator and chopper: offsets, fields, reset values, timing.
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the AHB-Lite bus).
// ----------------------------------------------------------------------------
`define STC_OFF_CTRL        12'h000
`define STC_OFF_CHOP_PERIOD 12'h004
`define STC_OFF_DBL_RC      12'h008
`define STC_OFF_STATUS      12'h00C

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define STC_CTRL_DBL_EN_BIT   0
`define STC_STAT_HOME_BIT     3
`define STC_STAT_LATCH1_BIT   4
`define STC_STAT_LATCH2_BIT   5
`define STC_STAT_HALF_BIT     6
`define STC_STAT_DIR_BIT      7
`define STC_STAT_ENABLE_BIT   8

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define STC_CTRL_RESET      1'h0
`define STC_HOME_POS        3'h0
`define STC_HOME_PHASES     4'h5

// ----------------------------------------------------------------------------
// Timing: times in ns, cycle counts derived from the clock period.
// ----------------------------------------------------------------------------
`define STC_CLK_PERIOD_NS   5
`define STC_CHOP_PERIOD_NS  50000
`define STC_DBL_RC_NS       20000
`define STC_DBL_FACTOR_NUM  3
`define STC_DBL_FACTOR_DEN  4

`endif

// ---- shared/stc_pkg.sv ----
// Types shared by the stepper translator and chopper design.
package stc_pkg;

  // Translator position: index 0 is state 1 (home).
  typedef logic [2:0] stc_pos_type;

  // Doubler sequencer states.
  typedef enum logic [0:0] {
    STC_DBL_IDLE = 1'b0,
    STC_DBL_WAIT = 1'b1
  } stc_dbl_state_type;

endpackage

// ---- hw/stc_sync.sv ----
// Three-stage input synchroniser with agreement filter, one lane per bit.
module stc_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------------------
  // Per-bit lanes.
  // ----------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_lane
      logic meta_r;
      logic mid_r;
      logic late_r;
      logic out_r;
      logic out_nxt;

      // A new level is accepted only when the second and third stages agree.
      always_comb begin
        out_nxt = out_r;
        if (mid_r == late_r) begin
          out_nxt = late_r;
        end
      end

      // The first stage feeds only the second, to keep metastability contained.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          mid_r  <= 1'b0;
          late_r <= 1'b0;
          out_r  <= 1'b0;
        end else begin
          meta_r <= async_in[gi];
          mid_r  <= meta_r;
          late_r <= mid_r;
          out_r  <= out_nxt;
        end
      end

      assign sync_out[gi] = out_r;
    end
  endgenerate

endmodule

// ---- hw/stc_top.sv ----
// Stepper translator, dual chopper and step doubler with an AHB-Lite register slave.
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`include "stc_cfg.svh"

// Contract
// R1 - Target select: low chops inhibits, high chops phases.
// R2 - Phase chopping drives inactive line of pair high.
// R3 - One oscillator pulse sets both chopper latches.
// R4 - Comparator trip resets its latch until oscillator.
// R5 - Doubler adds ghost step after 0.75 RC.
// R6 - Doubler disabled: only external steps advance.
// R7 - Each rising step edge advances one position.
// R8 - Anticlockwise walks the sequence in reverse.
// R9 - Translator reset returns to state 1, 0101.
// R10 - Half step visits all eight states.
// R11 - Full at odd state: two-phase-on, odd only.
// R12 - Two-phase-on keeps both inhibits high.
// R13 - Full at even state: wave drive, even only.
// R14 - Host waits 1 us after reset before step.
// R15 - Enable low forces inhibits and phases low.
// R16 - De-energised pair gets its inhibit pulled low.
// R17 - Home output active while at state 1.
// R18 - Direction input synchronised internally.
// R19 - Fixed eight-state phase map from 0101.
// R20 - Inputs synchronised, edge detected, one advance per edge.
module stc_top #(
  parameter int CHOP_CYCLES = `STC_CHOP_PERIOD_NS / `STC_CLK_PERIOD_NS,
  parameter int DBL_RC_CYCLES = `STC_DBL_RC_NS / `STC_CLK_PERIOD_NS
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Host-side control pins.
  input  wire logic        step_clock,
  input  wire logic        rotation_direction,
  input  wire logic        half_full,
  input  wire logic        translator_reset_n,
  input  wire logic        chip_enable,
  input  wire logic        chop_target,
  input  wire logic        current_sense_first,
  input  wire logic        current_sense_second,
  // Power-stage outputs.
  output logic      [3:0]  phase_outputs,
  output logic             inhibit_pair_ab_n,
  output logic             inhibit_pair_cd_n,
  output logic             home_out
);

  // ----------------------------------------------------------------------------
  // Input synchronisation.
  // ----------------------------------------------------------------------------
  logic [7:0] pins_s;
  logic       step_s;
  logic       dir_s;
  logic       half_s;
  logic       trst_n_s;
  logic       en_s;
  logic       target_s;
  logic       sense1_s;
  logic       sense2_s;

  // Every host-side control pin crosses into the core clock here; step is inverted so its idle level matches the lane reset. R18 R20
  stc_sync #(
    .WIDTH (8)
  ) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({current_sense_second, current_sense_first, chop_target, chip_enable,
                translator_reset_n, half_full, rotation_direction, ~step_clock}),
    .sync_out (pins_s)
  );

  assign step_s   = pins_s[0];
  assign dir_s    = pins_s[1];
  assign half_s   = pins_s[2];
  assign trst_n_s = pins_s[3];
  assign en_s     = pins_s[4];
  assign target_s = pins_s[5];
  assign sense1_s = pins_s[6];
  assign sense2_s = pins_s[7];

  // ----------------------------------------------------------------------------
  // Register file and AHB-Lite slave.
  // ----------------------------------------------------------------------------
  logic        dbl_en_r;
  logic        dbl_en_nxt;
  logic [15:0] chop_period_r;
  logic [15:0] chop_period_nxt;
  logic [15:0] dbl_rc_r;
  logic [15:0] dbl_rc_nxt;
  logic        wr_pend_r;
  logic        wr_pend_nxt;
  logic [11:0] wr_addr_r;
  logic [11:0] wr_addr_nxt;
  logic [31:0] hrdata_nxt;
  logic [31:0] status_word;
  logic        addr_phase;

  stc_pkg::stc_pos_type pos_r;
  logic        latch1_r;
  logic        latch2_r;

  assign addr_phase = hsel && hready && htrans[1];

  // Live state for software: position, home, latches, sampled mode pins.
  always_comb begin
    status_word                           = 32'h0000_0000;
    status_word[2:0]                      = pos_r;
    status_word[`STC_STAT_HOME_BIT]       = (pos_r == `STC_HOME_POS);
    status_word[`STC_STAT_LATCH1_BIT]     = latch1_r;
    status_word[`STC_STAT_LATCH2_BIT]     = latch2_r;
    status_word[`STC_STAT_HALF_BIT]       = half_s;
    status_word[`STC_STAT_DIR_BIT]        = dir_s;
    status_word[`STC_STAT_ENABLE_BIT]     = en_s;
  end

  // Writes land in the data phase; reads are decoded from the next values so
  // that a read right behind a write to the same register sees the new data.
  always_comb begin
    dbl_en_nxt      = dbl_en_r;
    chop_period_nxt = chop_period_r;
    dbl_rc_nxt      = dbl_rc_r;
    wr_pend_nxt     = addr_phase && hwrite;
    wr_addr_nxt     = addr_phase ? haddr : wr_addr_r;
    hrdata_nxt      = 32'h0000_0000;
    if (wr_pend_r) begin
      unique case (wr_addr_r)
        `STC_OFF_CTRL:        dbl_en_nxt = hwdata[`STC_CTRL_DBL_EN_BIT];
        `STC_OFF_CHOP_PERIOD: chop_period_nxt = hwdata[15:0];
        `STC_OFF_DBL_RC:      dbl_rc_nxt = hwdata[15:0];
        default:              dbl_en_nxt = dbl_en_r;
      endcase
    end
    if (addr_phase && !hwrite) begin
      unique case (haddr)
        `STC_OFF_CTRL:        hrdata_nxt = {31'h0000_0000, dbl_en_nxt};
        `STC_OFF_CHOP_PERIOD: hrdata_nxt = {16'h0000, chop_period_nxt};
        `STC_OFF_DBL_RC:      hrdata_nxt = {16'h0000, dbl_rc_nxt};
        `STC_OFF_STATUS:      hrdata_nxt = status_word;
        default:              hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Zero wait states: every transfer completes in its first data-phase cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dbl_en_r      <= `STC_CTRL_RESET;
      chop_period_r <= 16'(CHOP_CYCLES);
      dbl_rc_r      <= 16'(DBL_RC_CYCLES);
      wr_pend_r     <= 1'b0;
      wr_addr_r     <= 12'h000;
      hrdata        <= 32'h0000_0000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end else begin
      dbl_en_r      <= dbl_en_nxt;
      chop_period_r <= chop_period_nxt;
      dbl_rc_r      <= dbl_rc_nxt;
      wr_pend_r     <= wr_pend_nxt;
      wr_addr_r     <= wr_addr_nxt;
      hrdata        <= hrdata_nxt;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Step edge detection and pulse doubler.
  // ----------------------------------------------------------------------------
  logic                          step_prev_r;
  logic                          ext_step;
  stc_pkg::stc_dbl_state_type    dbl_state_r;
  stc_pkg::stc_dbl_state_type    dbl_state_nxt;
  logic [17:0]                   dbl_cnt_r;
  logic [17:0]                   dbl_cnt_nxt;
  logic [17:0]                   dbl_delay;
  logic                          ghost_step;

  // The lane holds the inverted pin, so a rising pin edge is a falling lane edge. R7 R20
  assign ext_step = !step_s && step_prev_r;

  // Ghost delay is 0.75 of the programmed RC product, never below one cycle. R5
  always_comb begin
    dbl_delay = 18'((18'(dbl_rc_r) * 18'(`STC_DBL_FACTOR_NUM)) / 18'(`STC_DBL_FACTOR_DEN));
    if (dbl_delay == 18'h0_0000) begin
      dbl_delay = 18'h0_0001;
    end
  end

  // A fresh external step restarts the wait, so a ghost never lands on top of
  // a real edge; with the doubler off no ghost is ever armed. R5 R6
  always_comb begin
    dbl_state_nxt = dbl_state_r;
    dbl_cnt_nxt   = dbl_cnt_r;
    ghost_step    = 1'b0;
    unique case (dbl_state_r)
      stc_pkg::STC_DBL_IDLE: begin
        if (ext_step && dbl_en_r) begin
          dbl_state_nxt = stc_pkg::STC_DBL_WAIT;
          dbl_cnt_nxt   = 18'h0_0001;
        end
      end
      stc_pkg::STC_DBL_WAIT: begin
        if (!dbl_en_r || !trst_n_s) begin
          dbl_state_nxt = stc_pkg::STC_DBL_IDLE;
        end else if (ext_step) begin
          dbl_cnt_nxt = 18'h0_0001;
        end else if (dbl_cnt_r >= dbl_delay) begin
          ghost_step    = 1'b1;
          dbl_state_nxt = stc_pkg::STC_DBL_IDLE;
        end else begin
          dbl_cnt_nxt = dbl_cnt_r + 18'h0_0001;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      step_prev_r <= 1'b0;
      dbl_state_r <= stc_pkg::STC_DBL_IDLE;
      dbl_cnt_r   <= 18'h0_0000;
    end else begin
      step_prev_r <= step_s;
      dbl_state_r <= dbl_state_nxt;
      dbl_cnt_r   <= dbl_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Translator.
  // ----------------------------------------------------------------------------
  stc_pkg::stc_pos_type pos_nxt;
  stc_pkg::stc_pos_type pos_delta;

  // Half step moves by one; full step moves by two, which keeps the parity the
  // translator had when full was chosen. The reset pin overrides stepping. R9
  always_comb begin
    pos_delta = half_s ? 3'h1 : 3'h2; // R10 R11 R13
    pos_nxt   = pos_r;
    if (!trst_n_s) begin
      pos_nxt = `STC_HOME_POS; // R9
    end else if (ext_step || ghost_step) begin
      if (dir_s) begin
        pos_nxt = pos_r + pos_delta; // R7
      end else begin
        pos_nxt = pos_r - pos_delta; // R8
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= `STC_HOME_POS;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Dual chopper.
  // ----------------------------------------------------------------------------
  logic [15:0] osc_cnt_r;
  logic [15:0] osc_cnt_nxt;
  logic        osc_pulse;
  logic        latch1_nxt;
  logic        latch2_nxt;

  // One free-running oscillator; a period of zero is treated as one cycle.
  always_comb begin
    osc_pulse   = 1'b0;
    osc_cnt_nxt = osc_cnt_r + 16'h0001;
    if (osc_cnt_r + 16'h0001 >= chop_period_r) begin
      osc_pulse   = 1'b1;
      osc_cnt_nxt = 16'h0000;
    end
  end

  // The oscillator pulse sets both latches; a comparator trip clears only its
  // own. The set wins a tie so that a drive period is never skipped. R3 R4
  always_comb begin
    latch1_nxt = latch1_r;
    latch2_nxt = latch2_r;
    if (osc_pulse) begin
      latch1_nxt = 1'b1; // R3
      latch2_nxt = 1'b1; // R3
    end else begin
      if (sense1_s) begin
        latch1_nxt = 1'b0; // R4
      end
      if (sense2_s) begin
        latch2_nxt = 1'b0; // R4
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r <= 16'h0000;
      latch1_r  <= 1'b1;
      latch2_r  <= 1'b1;
    end else begin
      osc_cnt_r <= osc_cnt_nxt;
      latch1_r  <= latch1_nxt;
      latch2_r  <= latch2_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Output stage.
  // ----------------------------------------------------------------------------
  logic [3:0] base_phases;
  logic       base_inh_ab;
  logic       base_inh_cd;
  logic [3:0] phase_nxt;
  logic       inh_ab_nxt;
  logic       inh_cd_nxt;
  logic       home_nxt;

  // Fixed rotating map; odd states drive two phases, even states one. R19
  always_comb begin
    unique case (pos_r)
      3'h0: base_phases = `STC_HOME_PHASES;
      3'h1: base_phases = 4'h1;
      3'h2: base_phases = 4'h9;
      3'h3: base_phases = 4'h8;
      3'h4: base_phases = 4'hA;
      3'h5: base_phases = 4'h2;
      3'h6: base_phases = 4'h6;
      3'h7: base_phases = 4'h4;
    endcase
  end

  // A pair with neither line active is inhibited for fast decay. In two-phase
  // drive every state energises both pairs, so both stay high. R16 R12
  assign base_inh_ab = base_phases[3] | base_phases[2];
  assign base_inh_cd = base_phases[1] | base_phases[0];

  // Chopping goes to the inhibits or to the phases; on the phases the idle line
  // of the pair is raised instead of dropping the active one. Enable low wins.
  always_comb begin
    phase_nxt  = base_phases;
    inh_ab_nxt = base_inh_ab;
    inh_cd_nxt = base_inh_cd;
    if (target_s) begin
      if (!latch1_r) begin
        phase_nxt[3:2] = 2'h3; // R1 R2
      end
      if (!latch2_r) begin
        phase_nxt[1:0] = 2'h3; // R1 R2
      end
    end else begin
      inh_ab_nxt = base_inh_ab & latch1_r; // R1
      inh_cd_nxt = base_inh_cd & latch2_r; // R1
    end
    if (!en_s) begin
      phase_nxt  = 4'h0; // R15
      inh_ab_nxt = 1'b0; // R15
      inh_cd_nxt = 1'b0; // R15
    end
    home_nxt = (pos_r == `STC_HOME_POS); // R17
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_outputs     <= 4'h0;
      inhibit_pair_ab_n <= 1'b0;
      inhibit_pair_cd_n <= 1'b0;
      home_out          <= 1'b1;
    end else begin
      phase_outputs     <= phase_nxt;
      inhibit_pair_ab_n <= inh_ab_nxt;
      inhibit_pair_cd_n <= inh_cd_nxt;
      home_out          <= home_nxt;
    end
  end

endmodule

// ---- tb/stc_top_sva.sv ----
// Concurrent checks on the ports of the stepper translator and chopper.
module stc_top_sva #(
  parameter int CHOP_CYCLES   = 20,
  parameter int DBL_RC_CYCLES = 8
) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       chip_enable,
  input wire logic       chop_target,
  input wire logic       current_sense_first,
  input wire logic       current_sense_second,
  input wire logic       translator_reset_n,
  input wire logic [3:0] phase_outputs,
  input wire logic       inhibit_pair_ab_n,
  input wire logic       inhibit_pair_cd_n,
  input wire logic       home_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------------------
  // Input histories long enough to cover the pin synchronisers.
  // ---------------------------------------------------------------------------
  sequence s_chop_inh;
    (current_sense_first && !chop_target && chip_enable)[*8];
  endsequence
  sequence s_chop_ph;
    (current_sense_second && chop_target && chip_enable)[*8];
  endsequence

  a_bus_okay_ready: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  a_enable_off_low: assert property (!chip_enable[*8] |-> phase_outputs == 4'h0 && !inhibit_pair_ab_n && !inhibit_pair_cd_n)
    else $error("outputs not forced low while disabled");
  a_home_flag_set: assert property (phase_outputs == 4'h5 && inhibit_pair_ab_n && inhibit_pair_cd_n |-> home_out)
    else $error("home indication missing at home pattern");
  a_ab_pair_decay: assert property (phase_outputs[3:2] == 2'b00 |-> !inhibit_pair_ab_n)
    else $error("idle first pair left enabled");
  a_cd_pair_decay: assert property (phase_outputs[1:0] == 2'b00 |-> !inhibit_pair_cd_n)
    else $error("idle second pair left enabled");
  a_reset_to_home: assert property (!translator_reset_n[*8] |-> home_out)
    else $error("translator not at home while reset is held");
  // The oscillator pulse may reopen the latch for one cycle, never for two.
  a_trip_holds_off: assert property (s_chop_inh |-> !(inhibit_pair_ab_n && $past(inhibit_pair_ab_n)))
    else $error("tripped channel kept driving its inhibit");
  a_trip_phases_up: assert property (s_chop_ph |-> phase_outputs[1:0] == 2'b11 || $past(phase_outputs[1:0]) == 2'b11)
    else $error("phase chopping did not raise both lines");
  cover property (s_chop_inh);
endmodule

bind stc_top stc_top_sva #(.CHOP_CYCLES(CHOP_CYCLES), .DBL_RC_CYCLES(DBL_RC_CYCLES)) u_sva (
  .clock(clock), .rst_n(rst_n), .hreadyout(hreadyout), .hresp(hresp), .chip_enable(chip_enable),
  .chop_target(chop_target), .current_sense_first(current_sense_first),
  .current_sense_second(current_sense_second), .translator_reset_n(translator_reset_n),
  .phase_outputs(phase_outputs), .inhibit_pair_ab_n(inhibit_pair_ab_n),
  .inhibit_pair_cd_n(inhibit_pair_cd_n), .home_out(home_out));

// ---- tb/stc_host.sv ----
// Behavioural host that pulses the step pin and the translator reset pin.
module stc_host (
  input  wire logic clock,
  input  wire logic go_step,
  input  wire logic go_reset,
  output logic      step_clock,
  output logic      translator_reset_n,
  output logic      busy
);
  timeunit 1ns;
  timeprecision 1ns;

  // The step pin idles high and steps on its rising edge; each level is held for
  // several clocks so the input filter sees it, and long enough for a ghost step.
  initial begin
    step_clock = 1'b1;
    translator_reset_n = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (go_reset) begin
        busy <= 1'b1;
        translator_reset_n <= 1'b0;
        repeat (8) @(posedge clock);
        translator_reset_n <= 1'b1;
        repeat (200) @(posedge clock);
        busy <= 1'b0;
      end else if (go_step) begin
        busy <= 1'b1;
        step_clock <= 1'b0;
        repeat (4) @(posedge clock);
        step_clock <= 1'b1;
        repeat (12) @(posedge clock);
        busy <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/test_stc_top.sv ----
// Self-checking bench of the stepper translator and chopper.
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_stc_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock, rst_n, hsel, hwrite, hreadyout, hresp, go_step, go_reset, busy;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        step_clock, rotation_direction, half_full, translator_reset_n, chip_enable;
  logic        chop_target, current_sense_first, current_sense_second, home_out;
  logic        inhibit_pair_ab_n, inhibit_pair_cd_n, s0, s1;
  logic [3:0]  phase_outputs;
  logic [3:0]  p0, p1;
  logic [3:0]  map [8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4};
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          idx;

  stc_top #(.CHOP_CYCLES(20), .DBL_RC_CYCLES(8)) u_dut (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .step_clock(step_clock), .rotation_direction(rotation_direction),
    .half_full(half_full), .translator_reset_n(translator_reset_n), .chip_enable(chip_enable),
    .chop_target(chop_target), .current_sense_first(current_sense_first),
    .current_sense_second(current_sense_second), .phase_outputs(phase_outputs),
    .inhibit_pair_ab_n(inhibit_pair_ab_n), .inhibit_pair_cd_n(inhibit_pair_cd_n), .home_out(home_out));

  stc_host u_host (.clock(clock), .go_step(go_step), .go_reset(go_reset), .step_clock(step_clock),
    .translator_reset_n(translator_reset_n), .busy(busy));

  // Free-running 200 MHz core clock.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // A hang counts as a mismatch; the run needs far fewer cycles than this.
  always @(posedge clock) begin
    cyc++;
    if (cyc >= 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------------
  // Bus, pin and comparison tasks.
  // ---------------------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask

  // The host is busy for the whole pulse, which outlasts the output latency.
  task automatic pulse(input logic rst);
    if (rst) go_reset <= 1'b1;
    else go_step <= 1'b1;
    @(posedge clock);
    go_step <= 1'b0;
    go_reset <= 1'b0;
    @(posedge clock);
    while (busy === 1'b1) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask

  task automatic chk_ph(input int i);
    `CHK("phases", map[i % 8], phase_outputs)
    `CHK("inh_ab", |map[i % 8][3:2], inhibit_pair_ab_n)
    `CHK("inh_cd", |map[i % 8][1:0], inhibit_pair_cd_n)
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    {rst_n, hsel, hwrite, go_step, go_reset, chop_target, current_sense_first, current_sense_second} = '0;
    {rotation_direction, half_full, chip_enable} = 3'b111;
    haddr = 12'h000;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (12) @(posedge clock);
    ahb(1'b0, 12'h000, 32'h0, rd); `CHK("ctrl", 32'h0, rd)
    ahb(1'b0, 12'h004, 32'h0, rd); `CHK("period", 32'h14, rd)
    ahb(1'b0, 12'h008, 32'h0, rd); `CHK("rc", 32'h8, rd)
    ahb(1'b1, 12'h004, 32'hFFFF_0014, rd);
    ahb(1'b0, 12'h004, 32'h0, rd); `CHK("period_wr", 32'h14, rd)
    ahb(1'b0, 12'h010, 32'h0, rd); `CHK("unmapped", 32'h0, rd)
    ahb(1'b0, 12'h00C, 32'h0, rd); `CHK("status", 4'h8, rd[3:0])
    $display("test registers done");
    for (idx = 1; idx <= 8; idx++) begin pulse(1'b0); chk_ph(idx); end
    rotation_direction <= 1'b0;
    for (idx = 7; idx >= 5; idx--) begin pulse(1'b0); chk_ph(idx); end
    rotation_direction <= 1'b1;
    for (idx = 6; idx <= 8; idx++) begin pulse(1'b0); chk_ph(idx); end
    $display("test half step done");
    half_full <= 1'b0;
    repeat (8) @(posedge clock);
    for (idx = 2; idx <= 8; idx += 2) begin pulse(1'b0); chk_ph(idx); end
    half_full <= 1'b1;
    repeat (8) @(posedge clock);
    pulse(1'b0);
    half_full <= 1'b0;
    repeat (8) @(posedge clock);
    for (idx = 3; idx <= 9; idx += 2) begin pulse(1'b0); chk_ph(idx); end
    $display("test full step done");
    pulse(1'b1);
    chk_ph(0);
    `CHK("home", 1'b1, home_out)
    half_full <= 1'b1;
    repeat (8) @(posedge clock);
    ahb(1'b1, 12'h000, 32'h1, rd);
    pulse(1'b0);
    chk_ph(2);
    ahb(1'b1, 12'h000, 32'h0, rd);
    pulse(1'b0);
    chk_ph(3);
    $display("test reset and doubler done");
    current_sense_first <= 1'b1;
    repeat (12) @(posedge clock);
    s0 = inhibit_pair_ab_n;
    @(posedge clock);
    s1 = inhibit_pair_ab_n;
    `CHK("trip_inh", 1'b0, s0 & s1)
    current_sense_first <= 1'b0;
    repeat (30) @(posedge clock);
    `CHK("reopen_inh", 1'b1, inhibit_pair_ab_n)
    chop_target <= 1'b1;
    current_sense_first <= 1'b1;
    current_sense_second <= 1'b1;
    repeat (12) @(posedge clock);
    p0 = phase_outputs;
    @(posedge clock);
    p1 = phase_outputs;
    `CHK("trip_ph", 1'b1, (p0[3:2] == 2'b11) | (p1[3:2] == 2'b11))
    `CHK("trip_ph_cd", 1'b1, (p0[1:0] == 2'b11) | (p1[1:0] == 2'b11))
    `CHK("inh_kept", 1'b1, inhibit_pair_ab_n)
    current_sense_first <= 1'b0;
    current_sense_second <= 1'b0;
    chop_target <= 1'b0;
    repeat (30) @(posedge clock);
    chk_ph(3);
    $display("test chopper done");
    chip_enable <= 1'b0;
    repeat (10) @(posedge clock);
    `CHK("off_out", 6'h00, {phase_outputs, inhibit_pair_ab_n, inhibit_pair_cd_n})
    chip_enable <= 1'b1;
    repeat (10) @(posedge clock);
    chk_ph(3);
    $display("test enable done");
    wrap_up();
  end
endmodule
